// *** verilog/pqi_pkg.sv ***
// Package of constants and types for the packet queue interrupt logic.
package pqi_pkg;
  localparam int NPKT   = 16;
  localparam int PW     = 6;
  localparam int QW     = 4;
  localparam logic [1:0] BANK_CTRL = 2'h0;
  localparam logic [1:0] BANK_CFG  = 2'h1;
  localparam logic [1:0] BANK_MMU  = 2'h2;
  localparam logic [3:0] OFS_0 = 4'h0;
  localparam logic [3:0] OFS_2 = 4'h2;
  localparam logic [3:0] OFS_4 = 4'h4;
  localparam logic [3:0] OFS_6 = 4'h6;
  localparam logic [3:0] OFS_C = 4'hC;
  localparam logic [3:0] OFS_D = 4'hD;
  localparam logic [15:0] CMD_RELEASE = 16'h00A0;
  localparam logic [15:0] CMD_REQUEUE = 16'h00C0;
  localparam logic [15:0] CMD_ALLOC   = 16'h0020;
  localparam logic [15:0] CMD_RX_POP  = 16'h0080;
  localparam logic [15:0] CMD_TX_SEND = 16'h00E0;
  localparam int B_RX = 0;
  localparam int B_TX = 1;
  localparam int B_TXE = 2;
  localparam int B_ALLOC = 3;
  localparam int B_TXON = 0;
  localparam int B_AUTOREL = 11;
  localparam int B_BADCRC = 14;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [PW-1:0] EMPTY_NUM = 6'h3F;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [1:0]  bank;
    logic [3:0]  ofs;
    logic [15:0] wdata;
  } pqi_req_t;
  typedef struct packed {
    logic          done;
    logic          ok;
    logic          fatal;
    logic [QW-1:0] num;
  } pqi_txres_t;
  typedef struct packed {
    logic          done;
    logic          crc_ok;
  } pqi_rxres_t;
endpackage

// *** verilog/pqi_core.sv ***
// Packet number queues, page allocator and interrupt flags for the buffer manager.
`timescale 1ns/1ps
module pqi_core import pqi_pkg::*; (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire pqi_req_t   req,
  input  wire pqi_txres_t tx_res,
  input  wire pqi_rxres_t rx_res,
  output logic [15:0]     rdata,
  output logic            irq,
  output logic            tx_go,
  output logic [QW-1:0]   tx_num,
  output logic            status_we,
  output logic [QW-1:0]   status_num,
  output logic            transmitter_on_bit
);
  logic [NPKT-1:0] used_q;
  logic [15:0]     txctl_q, cfg_q, rcr_q;
  logic [7:0]      packet_select_register;
  logic [7:0]      mask_q;
  logic [QW-1:0]   alloc_num_q;
  logic            alloc_fail_q, alloc_done_q;
  logic [QW-1:0]   txq [NPKT];
  logic [QW-1:0]   cq [NPKT];
  logic [QW-1:0]   rq [NPKT];
  logic [QW:0]     txq_n, cq_n, rq_n;
  logic            tx_go_q, irq_q, swe_q;
  logic            tx_busy_q;
  logic [QW-1:0]   snum_q;
  logic [QW-1:0]   free_num;
  logic            free_any;
  logic [QW:0]     free_cnt;
  logic            wr_mmu, rd_mmu, cmd_wr;
  logic [15:0]     cmd;
  logic            do_rel, do_rq, do_alloc, do_rxpop, do_send;
  logic            rx_ok, rx_take, cq_push, tx_pop, cq_pop;
  logic [7:0]      flags;
  logic [QW-1:0]   sel;
  logic            rx_queue_flag;

  assign sel    = packet_select_register[QW-1:0];
  assign wr_mmu = req.wr && req.bank == BANK_MMU;
  assign rd_mmu = req.rd && req.bank == BANK_MMU;
  assign cmd_wr = wr_mmu && req.ofs == OFS_0;
  assign cmd    = req.wdata;
  assign do_rel   = cmd_wr && cmd == CMD_RELEASE;
  assign do_rq    = cmd_wr && cmd == CMD_REQUEUE;
  assign do_alloc = cmd_wr && cmd == CMD_ALLOC;
  assign do_rxpop = cmd_wr && cmd == CMD_RX_POP;
  assign do_send  = cmd_wr && cmd == CMD_TX_SEND;

  // Lowest free page number and the count of free pages.
  always_comb begin
    free_num = '0;
    free_any = 1'b0;
    free_cnt = '0;
    for (int i = NPKT - 1; i >= 0; i--) begin
      if (!used_q[i]) begin
        free_num = QW'(i);
        free_any = 1'b1;
        free_cnt = free_cnt + 1'b1;
      end
    end
  end

  // Receive allocation may not eat into the reserve the host sets aside for transmit.
  assign rx_ok   = rx_res.crc_ok || rcr_q[B_BADCRC];
  // A host allocation wins the page in a shared cycle, so one page never lands in two queues.
  assign rx_take = rx_res.done && rx_ok && free_any && !do_alloc &&
                   free_cnt > {1'b0, cfg_q[QW-1:0]} && rq_n < (QW+1)'(NPKT);
  // Good packets under auto-release bypass the completion queue.
  assign cq_push = tx_res.done && !(tx_res.ok && txctl_q[B_AUTOREL] && !tx_res.fatal);
  assign tx_pop  = tx_go_q;
  assign cq_pop  = do_rel || do_rq;

  // Page ownership, freed by command or by auto-release.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      used_q <= '0;
    end else begin
      for (int i = 0; i < NPKT; i++) begin
        if (do_alloc && free_any && free_num == QW'(i)) used_q[i] <= 1'b1;
        if (rx_take && free_num == QW'(i) && !do_alloc) used_q[i] <= 1'b1;
        if (do_rel && sel == QW'(i)) used_q[i] <= 1'b0;
        if (do_rxpop && rq_n != '0 && rq[0] == QW'(i)) used_q[i] <= 1'b0;
        if (tx_res.done && !cq_push && tx_res.num == QW'(i)) used_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alloc_num_q  <= '0;
      alloc_fail_q <= 1'b0;
      alloc_done_q <= 1'b0;
    end else if (do_alloc) begin
      alloc_num_q  <= free_num;
      alloc_fail_q <= !free_any;
      alloc_done_q <= free_any;
    end
  end

  // Transmit queue: shifts forward on each start, so the next packet follows unattended.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txq_n   <= '0;
      tx_go_q <= 1'b0;
      for (int i = 0; i < NPKT; i++) txq[i] <= '0;
    end else begin
      tx_go_q <= !tx_go_q && !tx_busy_q && txq_n != '0 && transmitter_on_bit &&
                 !tx_res.done;
      for (int i = 0; i < NPKT - 1; i++) if (tx_pop) txq[i] <= txq[i+1];
      if ((do_send || do_rq) && txq_n < (QW+1)'(NPKT))
        txq[QW'(tx_pop ? txq_n - 1'b1 : txq_n)] <= sel;
      txq_n <= txq_n + (QW+1)'((do_send || do_rq) && txq_n < (QW+1)'(NPKT))
                     - (QW+1)'(tx_pop);
    end
  end

  // The engine takes one frame at a time, so the next start waits for the last result.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_busy_q <= 1'b0;
    end else if (tx_go_q) begin
      tx_busy_q <= 1'b1;
    end else if (tx_res.done) begin
      tx_busy_q <= 1'b0;
    end
  end

  // Completion queue keeps the order in which transmissions finish.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cq_n <= '0;
      for (int i = 0; i < NPKT; i++) cq[i] <= '0;
    end else begin
      for (int i = 0; i < NPKT - 1; i++) if (cq_pop && cq_n != '0) cq[i] <= cq[i+1];
      if (cq_push) cq[QW'((cq_pop && cq_n != '0) ? cq_n - 1'b1 : cq_n)] <= tx_res.num;
      cq_n <= cq_n + (QW+1)'(cq_push) - (QW+1)'(cq_pop && cq_n != '0);
    end
  end

  // Receive queue.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rq_n <= '0;
      for (int i = 0; i < NPKT; i++) rq[i] <= '0;
    end else begin
      for (int i = 0; i < NPKT - 1; i++) if (do_rxpop && rq_n != '0) rq[i] <= rq[i+1];
      if (rx_take) rq[QW'((do_rxpop && rq_n != '0) ? rq_n - 1'b1 : rq_n)] <= free_num;
      rq_n <= rq_n + (QW+1)'(rx_take) - (QW+1)'(do_rxpop && rq_n != '0);
    end
  end

  // Host registers; a fatal error drops the transmitter, but a host control write in the same cycle wins.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txctl_q <= RST_ZERO;
      cfg_q   <= RST_ZERO;
      rcr_q   <= RST_ZERO;
      packet_select_register <= '0;
      mask_q  <= '0;
    end else begin
      if (req.wr && req.bank == BANK_CTRL && req.ofs == OFS_0) txctl_q <= req.wdata;
      else if (tx_res.done && tx_res.fatal) txctl_q[B_TXON] <= 1'b0;
      if (req.wr && req.bank == BANK_CFG && req.ofs == OFS_0) cfg_q <= req.wdata;
      if (req.wr && req.bank == BANK_CFG && req.ofs == OFS_C) rcr_q <= req.wdata;
      if (wr_mmu && req.ofs == OFS_2) packet_select_register <= req.wdata[7:0];
      if (wr_mmu && req.ofs == OFS_D) mask_q <= req.wdata[7:0];
    end
  end
  assign transmitter_on_bit = txctl_q[B_TXON];

  // Flags are levels tied to queue state or to the last allocation result, so they cannot lose an event on acknowledge.
  assign rx_queue_flag = rq_n != '0;
  always_comb begin
    flags = '0;
    flags[B_RX]    = rx_queue_flag;
    flags[B_TX]    = cq_n != '0;
    flags[B_TXE]   = txq_n == '0 && !tx_go_q && !tx_busy_q;
    flags[B_ALLOC] = alloc_done_q;
  end

  // The interrupt line and the status write both trail their sources by one cycle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
      swe_q <= 1'b0;
      snum_q <= '0;
    end else begin
      irq_q  <= |(flags & mask_q);
      swe_q  <= tx_res.done;
      snum_q <= tx_res.num;
    end
  end

  always_comb begin
    rdata = RST_ZERO;
    if (req.rd && req.bank == BANK_CTRL && req.ofs == OFS_0) rdata = txctl_q;
    if (rd_mmu && req.ofs == OFS_2) rdata = {8'h00, packet_select_register};
    if (rd_mmu && req.ofs == OFS_4)
      rdata = {2'b00, rq_n != '0 ? {2'b00, rq[0]} : EMPTY_NUM,
               2'b00, cq_n != '0 ? {2'b00, cq[0]} : EMPTY_NUM};
    if (rd_mmu && req.ofs == OFS_C) rdata = {mask_q, flags};
    if (rd_mmu && req.ofs == OFS_6) rdata = {alloc_fail_q, 9'h000, 2'b00, alloc_num_q};
  end

  assign irq        = irq_q;
  assign tx_go      = tx_go_q;
  assign tx_num     = txq[0];
  assign status_we  = swe_q;
  assign status_num = snum_q;
endmodule // pqi_core

// *** dv/pqi_mac_model.sv ***
// Stand-in transmit engine that answers each send pulse after a chosen delay.
`timescale 1ns/1ps
module pqi_mac_model import pqi_pkg::*; (
  input  wire logic          core_clk,
  input  wire logic          tx_go,
  input  wire logic [QW-1:0] tx_num,
  input  wire logic          fail,
  input  wire logic [2:0]    dly,
  output pqi_txres_t         tx_res
);
  logic [QW-1:0] num;
  initial tx_res = '0;
  // The number field churns between frames so a stale value is never mistaken for a result.
  always @(negedge core_clk) begin
    tx_res.done = 1'b0;
    tx_res.num = ~tx_res.num;
    if (tx_go === 1'b1) begin
      num = tx_num;
      repeat (dly + 1) @(negedge core_clk);
      tx_res = '{1'b1, !fail, fail, num};
    end
  end
endmodule // pqi_mac_model

// *** dv/pqi_core_monitor.sv ***
// Checker bound to the packet queue interrupt core.
`timescale 1ns/1ps
module pqi_core_monitor import pqi_pkg::*; (
  input wire logic          core_clk,
  input wire logic          rst,
  input wire pqi_req_t      req,
  input wire pqi_txres_t    tx_res,
  input wire pqi_rxres_t    rx_res,
  input wire logic [15:0]   rdata,
  input wire logic          irq,
  input wire logic          tx_go,
  input wire logic [QW-1:0] tx_num,
  input wire logic          status_we,
  input wire logic [QW-1:0] status_num,
  input wire logic          transmitter_on_bit
);
  logic [3:0] mask_q;
  logic       busy_q;
  wire logic  ctl_wr = req.wr && req.bank == BANK_CTRL && req.ofs == OFS_0;
  wire logic  wbit = req.wdata[B_TXON];
  wire logic  hit = |(rdata[3:0] & mask_q);
  always_ff @(posedge core_clk or posedge rst)
    if (rst) mask_q <= 4'h0;
    else if (req.wr && req.bank == BANK_MMU && req.ofs == OFS_D) mask_q <= req.wdata[3:0];
  // A start is only owed while no frame is out with the engine.
  always_ff @(posedge core_clk or posedge rst)
    if (rst) busy_q <= 1'b0;
    else if (tx_go) busy_q <= 1'b1;
    else if (tx_res.done) busy_q <= 1'b0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_flag_rd;
    req.rd && req.bank == BANK_MMU && req.ofs == OFS_C;
  endsequence
  sequence s_send;
    req.wr && req.bank == BANK_MMU && req.ofs == OFS_0 && req.wdata == CMD_TX_SEND &&
      transmitter_on_bit;
  endsequence
  a_status_follows: assert property (tx_res.done |=> status_we)
    else $error("status write missing");
  a_status_cause: assert property (
    status_we |-> $past(tx_res.done) && status_num == $past(tx_res.num))
    else $error("status write without matching completion");
  a_txon_write: assert property (ctl_wr && !tx_res.done |=> transmitter_on_bit == $past(wbit))
    else $error("transmit enable not written");
  a_txon_hold: assert property (
    !ctl_wr && !tx_res.done && !status_we |=> $stable(transmitter_on_bit))
    else $error("transmit enable changed by itself");
  a_go_needs_on: assert property (tx_go |-> $past(transmitter_on_bit))
    else $error("send while transmitter off");
  a_send_starts: assert property ((s_send and (!tx_go && !busy_q)) |-> ##[1:2] tx_go)
    else $error("queued packet not started");
  a_irq_masked: assert property (irq |-> $past(mask_q) != 4'h0)
    else $error("interrupt with all sources masked");
  a_irq_follows: assert property (s_flag_rd |=> irq == $past(hit))
    else $error("interrupt does not follow enabled flags");
endmodule // pqi_core_monitor
bind pqi_core pqi_core_monitor i_pqi_core_monitor (.core_clk(core_clk), .rst(rst), .req(req),
  .tx_res(tx_res), .rx_res(rx_res), .rdata(rdata), .irq(irq), .tx_go(tx_go), .tx_num(tx_num),
  .status_we(status_we), .status_num(status_num), .transmitter_on_bit(transmitter_on_bit));

// *** dv/pqi_core_test.sv ***
// Self-checking bench for the packet queue interrupt core.
`timescale 1ns/1ps
module pqi_core_test import pqi_pkg::*;;
  logic          core_clk = 1'b0;
  logic          rst = 1'b1;
  logic          fail = 1'b0;
  logic [2:0]    dly = 3'h0;
  pqi_req_t      req = '0;
  pqi_rxres_t    rx_res = '0;
  pqi_txres_t    tx_res;
  logic [15:0]   rdata, got, n0, n1, sv;
  logic          irq, tx_go, status_we, transmitter_on_bit;
  logic [QW-1:0] tx_num, status_num;
  logic [31:0]   exp_q[$];
  int            failures = 0;
  int            checks = 0;
  int            seed = 32'hE994C4BF;
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("Error %0t: got %h expected %h", $time, a, e); end end
  always #20 core_clk = ~core_clk;
  pqi_core i_pqi_core (.core_clk(core_clk), .rst(rst), .req(req), .tx_res(tx_res),
    .rx_res(rx_res), .rdata(rdata), .irq(irq), .tx_go(tx_go), .tx_num(tx_num),
    .status_we(status_we), .status_num(status_num), .transmitter_on_bit(transmitter_on_bit));
  pqi_mac_model i_pqi_mac_model (.core_clk(core_clk), .tx_go(tx_go), .tx_num(tx_num),
    .fail(fail), .dly(dly), .tx_res(tx_res));
  always @(posedge core_clk) if (req.rd === 1'b1) begin
    `CHK(rdata & exp_q[0][31:16], exp_q[0][15:0])
    void'(exp_q.pop_front());
  end
  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Every access leaves one idle cycle, so the strobe is never raised twice in one step.
  task automatic acc(input logic w, input logic [1:0] b, input logic [3:0] o, input logic [15:0] d);
    @(negedge core_clk) req = '{w, !w, b, o, d};
    @(posedge core_clk) got = rdata;
    @(negedge core_clk) req = '0;
  endtask
  task automatic wr(input logic [1:0] b, input logic [3:0] o, input logic [15:0] d);
    acc(1'b1, b, o, d);
  endtask
  task automatic rd(input logic [1:0] b, input logic [3:0] o, input logic [15:0] m, e);
    exp_q.push_back({m, e});
    acc(1'b0, b, o, 16'h0000);
  endtask
  task automatic sent;
    int i;
    i = 0;
    while (status_we !== 1'b1 && i < 40) begin
      @(posedge core_clk) #1 i++;
    end
    if (status_we !== 1'b1) begin
      failures++;
      results;
    end
  endtask
  task automatic send(output logic [15:0] n);
    wr(BANK_MMU, OFS_0, CMD_ALLOC);
    rd(BANK_MMU, OFS_6, 16'h8000, 16'h0000);
    n = got & 16'h003F;
    wr(BANK_MMU, OFS_2, n);
    wr(BANK_MMU, OFS_0, CMD_TX_SEND);
    sent;
  endtask
  task automatic free(input logic [15:0] n);
    wr(BANK_MMU, OFS_2, n);
    wr(BANK_MMU, OFS_0, CMD_RELEASE);
  endtask
  task automatic rx(input logic good);
    @(negedge core_clk) rx_res = '{1'b1, good};
    @(negedge core_clk) rx_res = '0;
  endtask
  initial begin
    dly = 3'($random(seed));
    repeat (3) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    rd(BANK_MMU, OFS_C, 16'h0007, 16'h0004);
    rd(BANK_MMU, OFS_4, 16'hFFFF, 16'h3F3F);
    $display("reset test done");
    wr(BANK_CTRL, OFS_0, 16'h0001);
    send(n0);
    dly = 3'($random(seed));
    send(n1);
    rd(BANK_MMU, OFS_C, 16'h0006, 16'h0006);
    rd(BANK_MMU, OFS_4, 16'h003F, n0);
    wr(BANK_MMU, OFS_C, 16'h0002);
    free(n0);
    rd(BANK_MMU, OFS_4, 16'h003F, n1);
    free(n1);
    rd(BANK_MMU, OFS_C, 16'h0002, 16'h0000);
    $display("per packet test done");
    wr(BANK_CTRL, OFS_0, 16'h0801);
    send(n0);
    rd(BANK_MMU, OFS_4, 16'h003F, 16'h003F);
    fail = 1'b1;
    send(n1);
    fail = 1'b0;
    rd(BANK_MMU, OFS_C, 16'h0002, 16'h0002);
    rd(BANK_MMU, OFS_4, 16'h003F, n1);
    // The shared pointer lies outside this block, so the routine guards the select it shares.
    rd(BANK_MMU, OFS_2, 16'h00FF, n1);
    sv = got;
    wr(BANK_MMU, OFS_2, n1);
    wr(BANK_MMU, OFS_0, CMD_REQUEUE);
    rd(BANK_CTRL, OFS_0, 16'hFFFF, 16'h0800);
    wr(BANK_CTRL, OFS_0, got | 16'h0001);
    sent;
    wr(BANK_MMU, OFS_2, sv);
    rd(BANK_MMU, OFS_2, 16'h00FF, n1);
    rd(BANK_MMU, OFS_C, 16'h0006, 16'h0004);
    $display("auto release test done");
    rx(1'b0);
    rd(BANK_MMU, OFS_C, 16'h0001, 16'h0000);
    rx(1'b1);
    rd(BANK_MMU, OFS_C, 16'h0001, 16'h0001);
    wr(BANK_MMU, OFS_D, 16'h0001);
    @(negedge core_clk) `CHK(irq, 1'b1)
    wr(BANK_MMU, OFS_0, CMD_RX_POP);
    rd(BANK_MMU, OFS_C, 16'h0001, 16'h0000);
    @(negedge core_clk) `CHK(irq, 1'b0)
    $display("receive test done");
    wr(BANK_CFG, OFS_C, 16'h4000);
    rx(1'b0);
    rd(BANK_MMU, OFS_4, 16'h3F00, 16'h0000);
    wr(BANK_CFG, OFS_0, 16'h000F);
    rx(1'b1);
    wr(BANK_MMU, OFS_0, CMD_RX_POP);
    rd(BANK_MMU, OFS_C, 16'h0001, 16'h0000);
    $display("reserve test done");
    results;
  end
endmodule // pqi_core_test
